// ===== include/setf_pkg.sv
`default_nettype none
package setf_pkg;
	// byte framing: eight data clocks, then the acknowledge clock
	localparam int BYTE_W = 8;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic [3:0] CNT_DONE = 4'h9;
	// address byte fields
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int DIR_BIT = 0;
	localparam int HI_ADDR_MSB = 3;
	// array shape: 128 pages of 32 bytes
	localparam int ADDR_W = 12;
	localparam int PAGE_COUNT = 128;
	localparam int PAGE_BYTES = 32;
	localparam int PAGE_OFS_W = 5;
	localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
	localparam logic [PAGE_OFS_W-1:0] PAGE_OFS_STEP = 5'h01;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 12'h001;
	// write data buffer
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_W = ADDR_W + BYTE_W;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_AHI,
		ST_ALO,
		ST_WDATA,
		ST_RDATA
	} setf_state_e;
endpackage
`default_nettype wire

// ===== include/setf_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface setf_fifo_if #(parameter int W = 20);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	// the front end fills the buffer and relays the drain handshake
	modport user(output in_valid, output in_data, input in_ready,
		output out_ready, input out_valid, input out_data);
	modport fifo(input in_valid, input in_data, output in_ready,
		input out_ready, output out_valid, output out_data);
endinterface
`default_nettype wire

// ===== hdl/setf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module setf_fifo import setf_pkg::*; #(
	parameter int WIDTH = FIFO_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	setf_fifo_if.fifo f
);
	localparam int PW = $clog2(DEPTH);

	// pointers wrap naturally only for a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
	logic [PW:0] cnt_ff, nxt_cnt;
	logic ov_ff, nxt_ov;
	logic [WIDTH-1:0] od_ff, nxt_od;
	logic push, load;

	// output register refills when empty or being drained
	always_comb begin
		push = f.in_valid && f.in_ready;
		load = (cnt_ff != '0) && (!ov_ff || f.out_ready);
		nxt_wptr = wptr_ff + {{(PW-1){1'b0}}, push};
		nxt_rptr = rptr_ff + {{(PW-1){1'b0}}, load};
		nxt_cnt = cnt_ff + {{PW{1'b0}}, push} - {{PW{1'b0}}, load};
		nxt_ov = load || (ov_ff && !f.out_ready);
		nxt_od = load ? mem[rptr_ff] : od_ff;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff <= '0;
			ov_ff <= 1'b0;
			od_ff <= '0;
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
			cnt_ff <= nxt_cnt;
			ov_ff <= nxt_ov;
			od_ff <= nxt_od;
		end
	end

	// storage needs no reset; only counted words are ever read
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wptr_ff] <= f.in_data;
		end
	end

	// full counts the output stage too, so the buffer holds exactly DEPTH words
	assign f.in_ready = ((cnt_ff + {{PW{1'b0}}, ov_ff}) != DEPTH[PW:0]);
	assign f.out_valid = ov_ff;
	assign f.out_data = od_ff;
endmodule // setf_fifo
`default_nettype wire

// ===== hdl/setf_front.sv
// Behaviour
// RULE_01: sample on SCL rise, drive after fall
// RULE_02: MSB first, ninth clock for acknowledge
// RULE_03: SDA changes only while SCL low
// RULE_04: SDA fall, SCL high: start command
// RULE_05: SDA rise, SCL high: stop, standby
// RULE_06: repeated start begins new command
// RULE_07: master idles bus with both high
// RULE_08: release after eighth; ack low ninth
// RULE_09: acknowledger releases after ninth clock
// RULE_10: master nack on read ends transfer
// RULE_11: standby at power-up, stop, write end
// RULE_12: ignore bus until a start
// RULE_13: master recovers with start, nine, start-stop
// RULE_14: address byte: type, ignored, direction
// RULE_15: direction high reads, low writes
// RULE_16: type mismatch: no ack, standby
// RULE_17: two word address bytes follow
// RULE_18: first word byte gives bits 11:8
// RULE_19: second word byte gives bits 7:0
// RULE_20: array is 128 pages of 32
// RULE_21: any byte count per transfer; write bytes here go unacknowledged while the write buffer is full
// RULE_22: master clocks bytes without gaps
// RULE_23: no address ack during internal write
// RULE_24: synchronise lines, detect edges internally
`timescale 1ns/1ps
`default_nettype none
module setf_front import setf_pkg::*; #(
	parameter logic [3:0] P_TYPE_ID = 4'h5, // arbitrary value
	parameter int P_FIFO_DEPTH = FIFO_DEPTH
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_o,
	output logic o_sda_oe_n,
	input wire logic i_wr_busy,
	input wire logic [BYTE_W-1:0] i_rd_data,
	output logic o_rd_next,
	output logic [ADDR_W-1:0] o_addr,
	output logic o_standby,
	output logic o_wr_valid,
	output logic [ADDR_W-1:0] o_wr_addr,
	output logic [BYTE_W-1:0] o_wr_data,
	input wire logic i_wr_ready
);
	if (P_FIFO_DEPTH < 2) begin : g_bad_depth
		$error("write buffer needs at least two words");
	end
	if (PAGE_COUNT * PAGE_BYTES != (1 << ADDR_W)) begin : g_bad_shape
		$error("page shape does not cover the address space");
	end

	setf_fifo_if #(.W(FIFO_W)) wbuf ();

	setf_fifo #(.WIDTH(FIFO_W), .DEPTH(P_FIFO_DEPTH)) u_wbuf (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.f(wbuf.fifo)
	);

	// two-flop synchronisers plus one history stage per line
	logic scl_m_ff, scl_s_ff, scl_d_ff;
	logic sda_m_ff, sda_s_ff, sda_d_ff;
	logic scl_rise, scl_fall, start_det, stop_det;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			scl_m_ff <= 1'b1;
			scl_s_ff <= 1'b1;
			scl_d_ff <= 1'b1;
			sda_m_ff <= 1'b1;
			sda_s_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_m_ff <= i_scl; // [RULE_24]
			scl_s_ff <= scl_m_ff;
			scl_d_ff <= scl_s_ff;
			sda_m_ff <= i_sda;
			sda_s_ff <= sda_m_ff;
			sda_d_ff <= sda_s_ff;
		end
	end

	// conditions seen only on synchronised samples, never the raw pins
	always_comb begin
		scl_rise = scl_s_ff && !scl_d_ff; // [RULE_24]
		scl_fall = !scl_s_ff && scl_d_ff;
		start_det = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff; // [RULE_04]
		stop_det = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff; // [RULE_05]
	end

	setf_state_e state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [BYTE_W-1:0] shift_ff, nxt_shift;
	logic [BYTE_W-1:0] tx_ff, nxt_tx;
	logic dir_ff, nxt_dir;
	logic ack_ff, nxt_ack;
	logic oe_n_ff, nxt_oe_n;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic rd_next_ff, nxt_rd_next;
	logic push_ff, nxt_push;
	logic [FIFO_W-1:0] push_data_ff, nxt_push_data;
	logic standby_ff, nxt_standby;

	// protocol engine; stop beats start, both beat clock edges
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_shift = shift_ff;
		nxt_tx = tx_ff;
		nxt_dir = dir_ff;
		nxt_ack = ack_ff;
		nxt_oe_n = oe_n_ff;
		nxt_addr = addr_ff;
		nxt_rd_next = 1'b0;
		nxt_push = 1'b0;
		nxt_push_data = push_data_ff;
		if (stop_det) begin
			nxt_state = ST_IDLE; // [RULE_05] [RULE_11]
			nxt_cnt = CNT_ZERO;
			nxt_oe_n = 1'b1;
		end else if (start_det) begin
			nxt_state = ST_DEV; // [RULE_04] [RULE_06]
			nxt_cnt = CNT_ZERO;
			nxt_oe_n = 1'b1;
		end else if (state_ff != ST_IDLE) begin // [RULE_12]
			if (scl_rise) begin
				// data bits shift in MSB first; ninth clock samples the bus
				if (cnt_ff < CNT_ACK) begin
					nxt_shift = {shift_ff[BYTE_W-2:0], sda_s_ff}; // [RULE_01] [RULE_02]
				end else begin
					nxt_ack = sda_s_ff; // [RULE_08]
					if (state_ff == ST_RDATA && !sda_s_ff) begin
						nxt_addr = addr_ff + ADDR_STEP; // full wrap on reads
						nxt_rd_next = 1'b1;
					end
				end
				nxt_cnt = cnt_ff + 4'h1;
			end else if (scl_fall) begin
				if (cnt_ff == CNT_ACK) begin
					// acknowledge slot opens after the eighth falling edge
					nxt_oe_n = 1'b1; // [RULE_08]
					case (state_ff)
						ST_DEV: begin
							if (shift_ff[TYPE_MSB:TYPE_LSB] == P_TYPE_ID && !i_wr_busy) begin // [RULE_14] [RULE_16] [RULE_23]
								nxt_oe_n = 1'b0;
								nxt_dir = shift_ff[DIR_BIT]; // [RULE_15]
							end else begin
								nxt_state = ST_IDLE; // [RULE_16]
							end
						end
						ST_AHI: begin
							nxt_addr = {shift_ff[HI_ADDR_MSB:0], addr_ff[BYTE_W-1:0]}; // [RULE_18]
							nxt_oe_n = 1'b0;
						end
						ST_ALO: begin
							nxt_addr = {addr_ff[ADDR_W-1:BYTE_W], shift_ff}; // [RULE_19]
							nxt_oe_n = 1'b0;
						end
						ST_WDATA: begin
							// full buffer turns into a no-acknowledge, never a lost byte
							if (wbuf.in_ready && !push_ff) begin
								nxt_oe_n = 1'b0; // [RULE_21]
								nxt_push = 1'b1;
								nxt_push_data = {addr_ff, shift_ff};
								nxt_addr = {addr_ff[ADDR_W-1:PAGE_OFS_W],
									addr_ff[PAGE_OFS_W-1:0] + PAGE_OFS_STEP}; // [RULE_20]
							end
						end
						default: nxt_oe_n = 1'b1;
					endcase
				end else if (cnt_ff == CNT_DONE) begin
					// ninth clock over: release, then move on or give up
					nxt_cnt = CNT_ZERO;
					nxt_oe_n = 1'b1; // [RULE_09]
					if (ack_ff) begin
						nxt_state = ST_IDLE; // [RULE_10]
					end else begin
						case (state_ff)
							ST_DEV: nxt_state = dir_ff ? ST_RDATA : ST_AHI; // [RULE_15] [RULE_17]
							ST_AHI: nxt_state = ST_ALO; // [RULE_17]
							ST_ALO: nxt_state = ST_WDATA;
							default: nxt_state = state_ff;
						endcase
						if (nxt_state == ST_RDATA) begin
							nxt_oe_n = i_rd_data[BYTE_W-1]; // [RULE_02]
							nxt_tx = {i_rd_data[BYTE_W-2:0], 1'b0};
						end
					end
				end else if (state_ff == ST_RDATA) begin
					nxt_oe_n = tx_ff[BYTE_W-1]; // [RULE_01] [RULE_03]
					nxt_tx = {tx_ff[BYTE_W-2:0], 1'b0};
				end
			end
		end
		nxt_standby = (nxt_state == ST_IDLE); // [RULE_11]
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff <= ST_IDLE; // [RULE_11]
			cnt_ff <= CNT_ZERO;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			dir_ff <= 1'b0;
			ack_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			addr_ff <= ADDR_RST;
			rd_next_ff <= 1'b0;
			push_ff <= 1'b0;
			push_data_ff <= '0;
			standby_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			shift_ff <= nxt_shift;
			tx_ff <= nxt_tx;
			dir_ff <= nxt_dir;
			ack_ff <= nxt_ack;
			oe_n_ff <= nxt_oe_n;
			addr_ff <= nxt_addr;
			rd_next_ff <= nxt_rd_next;
			push_ff <= nxt_push;
			push_data_ff <= nxt_push_data;
			standby_ff <= nxt_standby;
		end
	end

	// open drain: only ever pulls low, so the data bit is constant zero
	logic sda_o_ff;
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sda_o_ff <= 1'b0;
		end else begin
			sda_o_ff <= 1'b0;
		end
	end

	// buffer hookup; drain side stalls the buffer, which then refuses bytes
	assign wbuf.in_valid = push_ff;
	assign wbuf.in_data = push_data_ff;
	assign wbuf.out_ready = i_wr_ready;
	assign o_wr_valid = wbuf.out_valid;
	assign o_wr_addr = wbuf.out_data[FIFO_W-1:BYTE_W];
	assign o_wr_data = wbuf.out_data[BYTE_W-1:0];
	assign o_sda_o = sda_o_ff;
	assign o_sda_oe_n = oe_n_ff;
	assign o_addr = addr_ff;
	assign o_rd_next = rd_next_ff;
	assign o_standby = standby_ff;

	a_sda_on_fall: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_01]
		$changed(oe_n_ff) |-> $past(scl_fall || start_det || stop_det))
		else $error("sda drive changed away from scl low");

	a_sda_stable_high: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_03]
		(scl_s_ff && scl_d_ff && !start_det && !stop_det) |=> $stable(oe_n_ff))
		else $error("sda drive moved while scl high");

	a_start_begins: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_04]
		(start_det && !stop_det) |=> (state_ff == ST_DEV && cnt_ff == CNT_ZERO && oe_n_ff))
		else $error("start did not open address phase");

	a_stop_standby: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_05]
		stop_det |=> (state_ff == ST_IDLE && oe_n_ff) ##1 standby_ff)
		else $error("stop did not return to standby");

	a_idle_ignores: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_12]
		(state_ff == ST_IDLE && !start_det) |=> (state_ff == ST_IDLE && oe_n_ff))
		else $error("activity accepted without start");

	a_type_mismatch: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_16]
		(scl_fall && !start_det && !stop_det && state_ff == ST_DEV && cnt_ff == CNT_ACK
		&& shift_ff[TYPE_MSB:TYPE_LSB] != P_TYPE_ID) |=> (oe_n_ff && state_ff == ST_IDLE))
		else $error("foreign type identifier acknowledged");

	a_busy_no_ack: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_23]
		(scl_fall && !start_det && !stop_det && state_ff == ST_DEV && cnt_ff == CNT_ACK
		&& i_wr_busy) |=> oe_n_ff)
		else $error("address acknowledged during internal write");

	a_nack_ends_read: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_10]
		(scl_fall && !start_det && !stop_det && state_ff == ST_RDATA && cnt_ff == CNT_DONE
		&& ack_ff) |=> (state_ff == ST_IDLE && oe_n_ff))
		else $error("read went on after master nack");

	a_hi_addr_taken: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_18]
		(scl_fall && !start_det && !stop_det && state_ff == ST_AHI && cnt_ff == CNT_ACK)
		|=> (addr_ff[ADDR_W-1:BYTE_W] == $past(shift_ff[HI_ADDR_MSB:0]) && !oe_n_ff))
		else $error("upper address bits not taken");

	a_lo_addr_taken: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_19]
		(scl_fall && !start_det && !stop_det && state_ff == ST_ALO && cnt_ff == CNT_ACK)
		|=> (addr_ff[BYTE_W-1:0] == $past(shift_ff) && !oe_n_ff))
		else $error("lower address bits not taken");

	a_ack_released: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_09]
		(scl_fall && cnt_ff == CNT_DONE && state_ff != ST_RDATA
		&& !(state_ff == ST_DEV && dir_ff)) |=> oe_n_ff)
		else $error("sda still held after ninth clock");

	a_write_push: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_21]
		(scl_fall && !start_det && !stop_det && state_ff == ST_WDATA && cnt_ff == CNT_ACK
		&& !oe_n_ff == 1'b0 && wbuf.in_ready && !push_ff) |=> (push_ff && !oe_n_ff))
		else $error("accepted write byte not buffered");
endmodule // setf_front
`default_nettype wire

// ===== tb/setf_master.sv
`timescale 1ns/1ps
`default_nettype none
module setf_master (
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	localparam realtime Q = 31.25; // quarter of the 125 ns link period
	logic act;
	// idle bus: both lines high, clock stands still
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
		act = 1'b0;
	end
	// start, or repeated start when a frame is open
	task automatic start();
		#1; // keeps bus edges off the system clock edge
		if (act) begin
			o_scl = 1'b0;
			#Q o_sda = 1'b1;
			#Q o_scl = 1'b1;
			#Q;
		end
		o_sda = 1'b0;
		#Q act = 1'b1;
	endtask
	task automatic stop();
		o_scl = 1'b0;
		#Q o_sda = 1'b0;
		#Q o_scl = 1'b1;
		#Q o_sda = 1'b1;
		#Q act = 1'b0;
	endtask
	// data moves in the low half, sampled mid high half
	task automatic bit_io(input logic b, output logic s);
		o_scl = 1'b0;
		#Q o_sda = b;
		#Q o_scl = 1'b1;
		#Q s = i_sda;
		#Q;
	endtask
	// msb first, no gaps, ninth clock for the answer
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s); // released for the receiver
		ack = ~s;
	endtask
	// own answer is dropped at the next low half
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(nack, s);
	endtask
	// clock parked low after a nack, so the slave's give-up shows before any stop
	task automatic scl_low();
		o_scl = 1'b0;
		#(2*Q);
	endtask
endmodule // setf_master
`default_nettype wire

// ===== tb/setf_front_test.sv
`timescale 1ns/1ps
`default_nettype none
module setf_front_test;
	import setf_pkg::*;
	localparam logic [3:0] TID = 4'hC; // arbitrary type code
	logic clk, rst_n, busy, rdy, sda_o, oe_n, rnext, stb, wv;
	logic [7:0] rd, wdata;
	logic [11:0] addr, waddr;
	wire logic scl, m_sda;
	wire logic sda = m_sda & (oe_n | sda_o); // pull-up when released
	int fails = 0;
	int cmp_count = 0;
	int rnext_seen = 0;
	setf_master m_u (.i_sda(sda), .o_scl(scl), .o_sda(m_sda));
	setf_front #(.P_TYPE_ID(TID)) dut_u (.i_sys_clk(clk), .i_resetn(rst_n),
		.i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe_n(oe_n),
		.i_wr_busy(busy), .i_rd_data(rd), .o_rd_next(rnext), .o_addr(addr),
		.o_standby(stb), .o_wr_valid(wv), .o_wr_addr(waddr),
		.o_wr_data(wdata), .i_wr_ready(rdy));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// array stand-in: byte follows the address one clock late
	always @(posedge clk)
		rd <= addr[7:0] ^ 8'h3C;
	// read-advance pulses stand one cycle; count each once
	always @(posedge clk)
		if (rnext === 1'b1)
			rnext_seen <= rnext_seen + 1;
	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic print_verdict();
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic s_reset();
		chk("oe_n", 12'(oe_n), 12'h001);
		chk("standby", 12'(stb), 12'h001);
		chk("addr", addr, 12'h000);
		chk("sda_o", 12'(sda_o), 12'h000);
	endtask
	// silent without start, then start, nine clocks, start, stop
	task automatic s_recover();
		logic a;
		#1;
		m_u.wbyte({TID, 4'h0}, a);
		chk("ack_nostart", 12'(a), 12'h000);
		m_u.start();
		m_u.wbyte(8'hFF, a);
		m_u.start();
		m_u.stop();
		cyc(8);
		chk("stb_recover", 12'(stb), 12'h001);
	endtask
	task automatic s_select();
		logic a;
		m_u.start();
		m_u.wbyte({~TID, 4'h0}, a);
		chk("ack_badtype", 12'(a), 12'h000);
		cyc(2);
		chk("stb_badtype", 12'(stb), 12'h001);
		busy <= 1'b1;
		m_u.start();
		m_u.wbyte({TID, 4'h0}, a);
		chk("ack_busy", 12'(a), 12'h000);
		cyc(1);
		busy <= 1'b0;
		m_u.start();
		m_u.wbyte({TID, 4'h0}, a);
		chk("ack_ready", 12'(a), 12'h001);
		chk("stb_busy", 12'(stb), 12'h000);
		m_u.stop();
		cyc(8);
		chk("stb_stop", 12'(stb), 12'h001);
	endtask
	// fill with the drain stalled, then drain and check page wrap
	task automatic s_fill();
		logic a;
		int n;
		rdy <= 1'b0;
		m_u.start();
		m_u.wbyte({TID, 4'h6}, a);
		m_u.wbyte(8'hF7, a);
		m_u.wbyte(8'hFE, a);
		chk("ack_word", 12'(a), 12'h001);
		chk("addr_word", addr, 12'h7FE);
		n = 0;
		a = 1'b1;
		while (a && n < 20) begin
			m_u.wbyte(8'(n + 8'h40), a);
			if (a)
				n++;
		end
		chk("acked", 12'(n), 12'(FIFO_DEPTH));
		m_u.stop();
		cyc(1);
		rdy <= 1'b1;
		n = 0;
		repeat (64) begin
			@(posedge clk);
			if (wv && rdy) begin
				chk("wr_addr", waddr, {7'h3F, 5'h1E + 5'(n)});
				chk("wr_data", 12'(wdata), 12'(n + 8'h40));
				n++;
			end
		end
		chk("drained", 12'(n), 12'(FIFO_DEPTH));
	endtask
	// random read: address write, repeated start, two bytes, nack
	task automatic s_read();
		logic a;
		logic [7:0] d;
		m_u.start();
		m_u.wbyte({TID, 4'h0}, a);
		m_u.wbyte(8'h00, a);
		m_u.wbyte(8'hFF, a);
		m_u.start();
		m_u.wbyte({TID, 4'h1}, a);
		chk("ack_read", 12'(a), 12'h001);
		m_u.rbyte(1'b0, d);
		chk("rd0", 12'(d), 12'h0C3);
		chk("addr_inc", addr, 12'h100);
		chk("rd_next_ack", 12'(rnext_seen), 12'h001);
		m_u.rbyte(1'b1, d);
		chk("rd1", 12'(d), 12'h03C);
		// standby follows the ninth falling edge, ahead of the stop
		m_u.scl_low();
		cyc(2);
		chk("stb_nack", 12'(stb), 12'h001);
		chk("rel_nack", 12'(oe_n), 12'h001);
		chk("rd_next_nack", 12'(rnext_seen), 12'h001);
		m_u.stop();
	endtask
	// a hung bus must not stall the run
	initial begin
		#200_000;
		fails++;
		print_verdict();
	end
	initial begin
		rst_n = 1'b0;
		busy = 1'b0;
		rdy = 1'b1;
		cyc(4);
		rst_n <= 1'b1;
		cyc(4);
		s_reset();
		s_recover();
		cyc(2);
		s_select();
		cyc(2);
		s_fill();
		cyc(2);
		s_read();
		print_verdict();
	end
endmodule // setf_front_test
`default_nettype wire
